// *** core/asf_pkg.sv ***
// Constants and types shared by the status flag logic
package asf_pkg;
	localparam int unsigned   STAT_W       = 8;
	localparam int unsigned   DATA_W       = 24;
	localparam int unsigned   CHAN_W       = 4;
	localparam int unsigned   IDX_W        = 6;
	localparam int unsigned   SHIFT_W      = 32;
	localparam int unsigned   CNT_W        = 6;
	localparam logic [5:0]    IDX_STATUS   = 6'h00;
	localparam logic [5:0]    IDX_DATA     = 6'h04;
	localparam logic [7:0]    STATUS_RESET = 8'h80;
	localparam int unsigned   POS_RDY      = 7;
	localparam int unsigned   POS_ERR      = 6;
	localparam int unsigned   POS_CRC      = 5;
	localparam int unsigned   POS_REG      = 4;
	localparam int unsigned   POS_WEN      = 7;
	localparam int unsigned   POS_RW       = 6;
	localparam logic          RDY_RESET    = 1'h1;
	localparam logic [3:0]    CHAN_RESET   = 4'h0;
	localparam logic [23:0]   FS_POS       = 24'hffffff;
	localparam logic [23:0]   FS_NEG       = 24'h000000;
	localparam logic [23:0]   DATA_RESET   = 24'h000000;
	localparam logic [5:0]    LEN_STATUS   = 6'h08;
	localparam logic [5:0]    LEN_DATA     = 6'h18;
	localparam logic [5:0]    LEN_DATA_ST  = 6'h20;
	localparam logic [2:0]    CMD_LAST     = 3'h7;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_CMD   = 4'b0010,
		ST_SHIFT = 4'b0100,
		ST_SKIP  = 4'b1000
	} asf_state_type;
endpackage

// *** core/asf_status_flags.sv ***
// Status register, ready indicator and serial read path of the converter
//
// Contract
// - 8-bit read-only status at index 0x00, reset value 0x80.
// - With append enabled, data register reads are followed by the status byte.
// - Chip select low and no read running: data-out carries the ready indicator.
// - A new conversion result clears the ready indicator to 0.
// - In calibration mode, a finished calibration clears the indicator instead.
// - A data register read sets the ready indicator back to 1, unless a clear lands in the same cycle.
// - Outside calibration mode, over/underrange sets the range error and clamps result to full scale.
// - Range error only changes on result writes, clearing once in range.
// - A register write failing its CRC sets the CRC error flag.
// - A status register read clears the CRC error flag, unless a failure lands in the same cycle.
// - While checking is enabled, a register mismatch sets the integrity flag.
// - The integrity flag clears only when checking is disabled.
// - Bits 3..0 hold the channel of the result in the data register.
// - Channel field is the plain binary channel register number.
// - Command byte: read/write bit plus 6-bit register index; 0 is status.
`timescale 1ns/10ps
module asf_status_flags (
	input  wire logic                        clk,
	input  wire logic                        rst_b,
	input  wire logic                        sclkPin,
	input  wire logic                        csPin_b,
	input  wire logic                        dinPin,
	output logic                             doutData_ff,
	output logic                             doutEn_ff,
	input  wire logic                        resultWrite,
	input  wire logic [asf_pkg::DATA_W-1:0]  rawResult,
	input  wire logic                        overRange,
	input  wire logic                        underRange,
	input  wire logic [asf_pkg::CHAN_W-1:0]  resultChannel,
	input  wire logic                        calMode,
	input  wire logic                        calDone,
	input  wire logic                        crcFail,
	input  wire logic                        appendStatus,
	input  wire logic                        regCheckEn,
	input  wire logic                        regMismatch,
	output logic [asf_pkg::STAT_W-1:0]       statusFlags_ff,
	output logic [asf_pkg::DATA_W-1:0]       dataReg_ff,
	output logic                             cmdValid_ff,
	output logic                             cmdRead_ff,
	output logic [asf_pkg::IDX_W-1:0]        reg_index_ff
);
	import asf_pkg::*;

	logic                 sclkS1_ff;
	logic                 sclkS2_ff;
	logic                 sclkS3_ff;
	logic                 csS1_ff;
	logic                 csS2_ff;
	logic                 dinS1_ff;
	logic                 dinS2_ff;
	logic                 sclkRise;
	logic                 sclkFall;
	logic                 csLow;
	asf_state_type        state_ff;
	asf_state_type        nxt_state;
	logic [2:0]           cmdCnt_ff;
	logic [6:0]           cmdShift_ff;
	logic [7:0]           cmdByte;
	logic                 cmdDone;
	logic                 cmdIsRead;
	logic                 statusRead;
	logic                 dataRead;
	logic                 skipRead_ff;
	logic [SHIFT_W-1:0]   shreg_ff;
	logic [CNT_W-1:0]     bitsLeft_ff;
	logic                 bitOut_ff;
	logic                 rdy_ff;
	logic                 rdyClr;
	logic                 errFlag_ff;
	logic                 crcErr_ff;
	logic                 regErr_ff;
	logic [CHAN_W-1:0]    chan_ff;
	logic [STAT_W-1:0]    statusNow;

	// Pin synchronisers; the second stage is looked at, and the serial clock also has a third for edge detection
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sclkS1_ff <= 1'b1;
			sclkS2_ff <= 1'b1;
			sclkS3_ff <= 1'b1;
			csS1_ff   <= 1'b1;
			csS2_ff   <= 1'b1;
			dinS1_ff  <= 1'b0;
			dinS2_ff  <= 1'b0;
		end else begin
			sclkS1_ff <= sclkPin;
			sclkS2_ff <= sclkS1_ff;
			sclkS3_ff <= sclkS2_ff;
			csS1_ff   <= csPin_b;
			csS2_ff   <= csS1_ff;
			dinS1_ff  <= dinPin;
			dinS2_ff  <= dinS1_ff;
		end
	end

	assign sclkRise = sclkS2_ff & ~sclkS3_ff;
	assign sclkFall = ~sclkS2_ff & sclkS3_ff;
	assign csLow    = ~csS2_ff;

	// Command byte decode on the eighth rising edge
	assign cmdByte    = {cmdShift_ff, dinS2_ff};
	assign cmdDone    = (state_ff == ST_CMD) && csLow && sclkRise && (cmdCnt_ff == CMD_LAST);
	assign cmdIsRead  = cmdByte[POS_RW];
	assign statusRead = cmdDone && !cmdByte[POS_WEN] && cmdIsRead
		&& (cmdByte[IDX_W-1:0] == IDX_STATUS);
	assign dataRead   = cmdDone && !cmdByte[POS_WEN] && cmdIsRead
		&& (cmdByte[IDX_W-1:0] == IDX_DATA);

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (csLow) begin
					nxt_state = ST_CMD;
				end
			end
			ST_CMD: begin
				if (!csLow) begin
					nxt_state = ST_IDLE;
				end else if (cmdDone) begin
					// Foreign registers, writes and a high enable bit leave the frame to others
					if (statusRead || dataRead) begin
						nxt_state = ST_SHIFT;
					end else begin
						nxt_state = ST_SKIP;
					end
				end
			end
			ST_SHIFT: begin
				if (!csLow) begin
					nxt_state = ST_IDLE;
				end else if (sclkRise && (bitsLeft_ff == CNT_W'(1))) begin
					nxt_state = ST_CMD;
				end
			end
			ST_SKIP: begin
				if (!csLow) begin
					nxt_state = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cmdCnt_ff   <= 3'h0;
			cmdShift_ff <= 7'h00;
		end else if (state_ff != ST_CMD || !csLow) begin
			cmdCnt_ff   <= 3'h0;
			cmdShift_ff <= 7'h00;
		end else if (sclkRise) begin
			cmdCnt_ff   <= cmdCnt_ff + 3'h1;
			cmdShift_ff <= cmdByte[6:0];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			skipRead_ff <= 1'b0;
		end else if (cmdDone) begin
			skipRead_ff <= cmdIsRead && !cmdByte[POS_WEN] && !statusRead && !dataRead;
		end else if (state_ff == ST_IDLE) begin
			skipRead_ff <= 1'b0;
		end
	end

	// Command hand-off to the rest of the register file
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cmdValid_ff  <= 1'b0;
			cmdRead_ff   <= 1'b0;
			reg_index_ff <= 6'h00;
		end else begin
			cmdValid_ff <= cmdDone && !cmdByte[POS_WEN];
			if (cmdDone) begin
				cmdRead_ff   <= cmdIsRead;
				reg_index_ff <= cmdByte[IDX_W-1:0];
			end
		end
	end

	// Reply shifter; status is captured before the read side effects land
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			shreg_ff    <= 32'h00000000;
			bitsLeft_ff <= 6'h00;
			bitOut_ff   <= 1'b0;
		end else if (statusRead) begin
			shreg_ff    <= {statusNow, 24'h000000};
			bitsLeft_ff <= LEN_STATUS;
		end else if (dataRead) begin
			shreg_ff <= {dataReg_ff, statusNow};
			if (appendStatus) begin
				bitsLeft_ff <= LEN_DATA_ST;
			end else begin
				bitsLeft_ff <= LEN_DATA;
			end
		end else if (state_ff == ST_SHIFT) begin
			if (sclkFall) begin
				bitOut_ff <= shreg_ff[SHIFT_W-1];
				shreg_ff  <= {shreg_ff[SHIFT_W-2:0], 1'b0};
			end
			if (sclkRise) begin
				bitsLeft_ff <= bitsLeft_ff - CNT_W'(1);
			end
		end
	end

	// Data-out pin: reply bits during a read, else the ready indicator
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			doutData_ff <= 1'b1;
			doutEn_ff   <= 1'b0;
		end else begin
			doutEn_ff <= csLow && !(state_ff == ST_SKIP && skipRead_ff);
			if (state_ff == ST_SHIFT) begin
				doutData_ff <= bitOut_ff;
			end else begin
				doutData_ff <= rdy_ff;
			end
		end
	end

	// Ready indicator; a clear (result, or calibration done in calibration mode) landing with a data read wins
	assign rdyClr = calMode ? calDone : resultWrite;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdy_ff <= RDY_RESET;
		end else if (rdyClr) begin
			rdy_ff <= 1'b0;
		end else if (dataRead) begin
			rdy_ff <= 1'b1;
		end
	end

	// Result capture, clamping, range error and channel
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dataReg_ff <= DATA_RESET;
			errFlag_ff <= 1'b0;
			chan_ff    <= CHAN_RESET;
		end else if (resultWrite && !calMode) begin
			errFlag_ff <= overRange || underRange;
			chan_ff    <= resultChannel;
			if (overRange) begin
				dataReg_ff <= FS_POS;
			end else if (underRange) begin
				dataReg_ff <= FS_NEG;
			end else begin
				dataReg_ff <= rawResult;
			end
		end
	end

	// Write CRC error; a new failure beats the clearing read
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			crcErr_ff <= 1'b0;
		end else if (crcFail) begin
			crcErr_ff <= 1'b1;
		end else if (statusRead) begin
			crcErr_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			regErr_ff <= 1'b0;
		end else if (!regCheckEn) begin
			regErr_ff <= 1'b0;
		end else if (regMismatch) begin
			regErr_ff <= 1'b1;
		end
	end

	assign statusNow = {rdy_ff, errFlag_ff, crcErr_ff, regErr_ff, chan_ff};

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			statusFlags_ff <= STATUS_RESET;
		end else begin
			statusFlags_ff <= statusNow;
		end
	end

	sequence seqStatusCmd;
		statusRead && !crcFail;
	endsequence

	sequence seqDataCmd;
		dataRead && !rdyClr;
	endsequence

	a_dout_ready: assert property (@(posedge clk) disable iff (!rst_b)
		(csLow && state_ff != ST_SHIFT && !(state_ff == ST_SKIP && skipRead_ff)) |=>
		(doutEn_ff && doutData_ff == $past(rdy_ff))) else $error("data-out lost ready");
	a_append_len: assert property (@(posedge clk) disable iff (!rst_b)
		(dataRead && appendStatus) |=> (bitsLeft_ff == 6'h20 && shreg_ff[7:0] == $past(statusNow)))
		else $error("appended status missing from data read");
	a_result_clear: assert property (@(posedge clk) disable iff (!rst_b)
		(resultWrite && !calMode) |=> !rdy_ff)
		else $error("result did not clear ready");
	a_cal_clear: assert property (@(posedge clk) disable iff (!rst_b)
		(calMode && resultWrite && !calDone && !dataRead) |=> rdy_ff == $past(rdy_ff))
		else $error("conversion result moved ready in calibration");
	a_read_sets: assert property (@(posedge clk) disable iff (!rst_b)
		seqDataCmd |=> rdy_ff ##1 (rdy_ff || $past(rdyClr)))
		else $error("data read did not set ready");
	a_range_clamp: assert property (@(posedge clk) disable iff (!rst_b)
		(resultWrite && !calMode && overRange) |=> (errFlag_ff && dataReg_ff == 24'hffffff))
		else $error("overrange not flagged or clamped");
	a_range_hold: assert property (@(posedge clk) disable iff (!rst_b)
		!(resultWrite && !calMode) |=> $stable(errFlag_ff) && $stable(chan_ff))
		else $error("range error changed without result");
	a_crc_clear: assert property (@(posedge clk) disable iff (!rst_b)
		seqStatusCmd |=> !crcErr_ff ##1 (!crcErr_ff || $past(crcFail)))
		else $error("status read did not clear crc error");
	a_integrity_flag: assert property (@(posedge clk) disable iff (!rst_b)
		(regCheckEn && regMismatch) |=> regErr_ff until_with !regCheckEn)
		else $error("integrity flag dropped while checking");
	a_chan_field: assert property (@(posedge clk) disable iff (!rst_b)
		(resultWrite && !calMode) |=> chan_ff == $past(resultChannel))
		else $error("channel field wrong");
	a_status_wr_ign: assert property (@(posedge clk) disable iff (!rst_b)
		(cmdDone && !cmdIsRead && !crcFail)
		|=> state_ff == ST_SKIP && $stable(crcErr_ff) ##1 !cmdValid_ff)
		else $error("write command not skipped");
endmodule

// *** testbench/asf_host_model.sv ***
// Host serial controller model: drives chip select, serial clock and command bits
`timescale 1ns/10ps
module asf_host_model (
	input  wire logic clk,
	output logic      sclkPin,
	output logic      csPin_b,
	output logic      dinPin,
	input  wire logic doutData_ff,
	input  wire logic doutEn_ff
);
	initial begin
		sclkPin = 1'b1;
		csPin_b = 1'b1;
		dinPin  = 1'b1;
	end

	// Chip select changes, then lets the synchroniser settle
	task automatic select(input logic lvl);
		@(posedge clk);
		csPin_b <= lvl;
		repeat (8) @(posedge clk);
	endtask

	// Command byte MSB first, then nBits reply bits; clock idles high, period 8 clk
	task automatic frame(input logic [7:0] cmd, input int nBits, output logic [31:0] rx);
		rx = '0;
		for (int i = 0; i < 8 + nBits; i++) begin
			@(posedge clk);
			sclkPin <= 1'b0;
			dinPin  <= (i < 8) ? cmd[7-i] : ~dinPin;
			repeat (4) @(posedge clk);
			sclkPin <= 1'b1;
			repeat (3) @(posedge clk);
			// Reply bit is taken as is; any read check is the host's own job
			// A pin the device does not drive reads as the inverse of its last value
			if (i >= 8) rx = {rx[30:0], (doutEn_ff ? doutData_ff : ~doutData_ff)};
		end
	endtask
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the status flag logic against a reference flag model
`timescale 1ns/10ps
module testbench;
	import asf_pkg::*;
	logic              clk           = 1'b0;
	logic              rst_b         = 1'b0;
	logic              sclkPin;
	logic              csPin_b;
	logic              dinPin;
	logic              doutData_ff;
	logic              doutEn_ff;
	logic              resultWrite;
	logic [DATA_W-1:0] rawResult;
	logic              overRange;
	logic              underRange;
	logic [CHAN_W-1:0] resultChannel;
	logic              calMode;
	logic              calDone;
	logic              crcFail;
	logic              appendStatus;
	logic              regCheckEn;
	logic              regMismatch;
	logic [STAT_W-1:0] statusFlags_ff;
	logic [DATA_W-1:0] dataReg_ff;
	logic              cmdValid_ff;
	logic              cmdRead_ff;
	logic [IDX_W-1:0]  reg_index_ff;
	logic [31:0]       rx;
	logic [31:0]       exp;
	int                seed       = 12;
	int                failures   = 0;
	int                n_compared = 0;
	int                nValid     = 0;
	int                mRdy = 1, mErr = 0, mCrc = 0, mReg = 0, mChan = 0, mData = 0;

	always #5 clk = ~clk;

	asf_status_flags u_asf_status_flags (.clk, .rst_b, .sclkPin, .csPin_b, .dinPin,
		.doutData_ff, .doutEn_ff, .resultWrite, .rawResult, .overRange, .underRange,
		.resultChannel, .calMode, .calDone, .crcFail, .appendStatus, .regCheckEn,
		.regMismatch, .statusFlags_ff, .dataReg_ff, .cmdValid_ff, .cmdRead_ff, .reg_index_ff);

	asf_host_model u_asf_host_model (.clk, .sclkPin, .csPin_b, .dinPin, .doutData_ff,
		.doutEn_ff);

	// Command hand-off pulses, checked as a total at the end
	always @(posedge clk) begin
		if (cmdValid_ff) begin
			nValid++;
		end
	end

	function automatic logic [7:0] expStat();
		return {mRdy[0], mErr[0], mCrc[0], mReg[0], mChan[3:0]};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		n_compared++;
		if (got !== want) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask

	task automatic settle();
		repeat (3) @(posedge clk);
		chk(statusFlags_ff, expStat());
	endtask

	task automatic result(input logic ov, input logic un, input logic [3:0] ch);
		logic [23:0] raw;
		raw = 24'($random(seed));
		@(posedge clk);
		resultWrite   <= 1'b1;
		rawResult     <= raw;
		overRange     <= ov;
		underRange    <= un;
		resultChannel <= ch;
		@(posedge clk);
		resultWrite <= 1'b0;
		if (!calMode) begin
			mData = ov ? FS_POS : (un ? FS_NEG : raw);
			mErr  = ov | un;
			mChan = ch;
			mRdy  = 0;
		end
		settle();
		chk(dataReg_ff, mData);
	endtask

	task automatic complete_run();
		$display("compared=%0d failures=%0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		#500000;
		failures++;
		complete_run();
	end

	initial begin
		resultWrite   <= 1'b0;
		rawResult     <= 24'($random(seed));
		overRange     <= 1'($random(seed));
		underRange    <= 1'($random(seed));
		resultChannel <= 4'($random(seed));
		calMode       <= 1'b0;
		calDone       <= 1'b0;
		crcFail       <= 1'b0;
		appendStatus  <= 1'b0;
		regCheckEn    <= 1'b0;
		regMismatch   <= 1'b0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		chk(statusFlags_ff, STATUS_RESET);
		u_asf_host_model.select(1'b0);
		chk({doutEn_ff, doutData_ff}, 2'h3);
		u_asf_host_model.frame(8'h40, 8, rx);
		chk(rx, STATUS_RESET);
		chk({cmdRead_ff, reg_index_ff}, {1'b1, IDX_STATUS});
		u_asf_host_model.select(1'b1);
		$display("reset and status read done");
		for (int i = 0; i < 8; i++) begin
			result(i == 3, i == 5, (i < 3) ? 4'(i) : 4'($random(seed)));
		end
		$display("result writes done");
		for (int ap = 0; ap < 2; ap++) begin
			result(1'b0, 1'b0, 4'(ap + 6));
			@(posedge clk);
			appendStatus <= ap[0];
			u_asf_host_model.select(1'b0);
			chk({doutEn_ff, doutData_ff}, 2'h2);
			exp = ap ? {mData[23:0], expStat()} : 32'(mData);
			u_asf_host_model.frame(8'h44, 24 + 8 * ap, rx);
			chk(rx, exp);
			mRdy = 1;
			settle();
			u_asf_host_model.select(1'b1);
		end
		$display("data reads done");
		@(posedge clk);
		crcFail <= 1'b1;
		@(posedge clk);
		crcFail <= 1'b0;
		mCrc = 1;
		settle();
		u_asf_host_model.select(1'b0);
		u_asf_host_model.frame(8'h00, 8, rx);
		u_asf_host_model.select(1'b1);
		settle();
		u_asf_host_model.select(1'b0);
		u_asf_host_model.frame(8'hc0, 8, rx);
		u_asf_host_model.select(1'b1);
		settle();
		u_asf_host_model.select(1'b0);
		u_asf_host_model.frame(8'h40, 8, rx);
		chk(rx, expStat());
		mCrc = 0;
		u_asf_host_model.select(1'b1);
		settle();
		$display("write error flag done");
		// Mismatches with checking off and calibration pulses outside calibration do nothing
		repeat (4) begin
			@(posedge clk);
			regMismatch <= 1'($random(seed));
			calDone     <= 1'($random(seed));
		end
		@(posedge clk);
		regMismatch <= 1'b0;
		calDone     <= 1'b0;
		settle();
		@(posedge clk);
		regCheckEn  <= 1'b1;
		regMismatch <= 1'b1;
		@(posedge clk);
		regMismatch <= 1'b0;
		mReg = 1;
		settle();
		settle();
		@(posedge clk);
		regCheckEn <= 1'b0;
		mReg = 0;
		settle();
		$display("integrity flag done");
		@(posedge clk);
		calMode <= 1'b1;
		result(1'b1, 1'b0, 4'hc);
		@(posedge clk);
		calDone <= 1'b1;
		@(posedge clk);
		calDone <= 1'b0;
		mRdy = 0;
		settle();
		$display("calibration done");
		chk(nValid, 32'h5);
		complete_run();
	end
endmodule
